// File: inc/cis_pkg.sv
// package: encodings, constants and carriers for the instruction subset executor
package cis_pkg;
  localparam logic [3:0]  OP_TOGGLE_PFX = 4'h7;
  localparam logic [6:0]  OP_CLEAR_PFX  = 7'h35;
  localparam logic [7:0]  OP_BR_OVF     = 8'he4;
  localparam logic [7:0]  OP_BR_ZERO    = 8'he0;
  localparam logic [6:0]  OP_CALL_PFX   = 7'h76;
  localparam logic [3:0]  OP_CALL2_PFX  = 4'hf;
  localparam logic [15:0] OP_WDT_CLR    = 16'h0004;
  localparam logic [7:0]  LIT_OFS_MAX   = 8'h5f;
  localparam logic [20:0] PC_STEP       = 21'h000002;
  localparam logic [20:0] PC_RET_OFS    = 21'h000004;
  localparam logic [20:0] PC_RESET      = 21'h000000;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [3:0]  BANK_RESET    = 4'h0;
  localparam logic [7:0]  WDT_RESET     = 8'h00;
  localparam logic [3:0]  POST_RESET    = 4'h0;
  localparam int          ST_Z          = 2;
  localparam int          ST_OV         = 3;

  typedef enum logic [1:0] {
    CIS_EXEC  = 2'b00,
    CIS_FLUSH = 2'b01
  } cis_state_t;

  // data memory access request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       indexed;
    logic [11:0] addr;
    logic [7:0] wdata;
  } cis_dmem_t;

  // shadow register set
  typedef struct packed {
    logic [7:0] working;
    logic [7:0] status;
    logic [3:0] bank;
  } cis_shadow_t;
endpackage : cis_pkg

// File: rtl/cis_addr_gen.sv
// file address generator: access bank, banked and indexed literal offset
`timescale 1ns/10ps
module cis_addr_gen (
  input  wire logic [7:0]  file_addr,
  input  wire logic        access_sel,
  input  wire logic        ext_set_en,
  input  wire logic [3:0]  bank_select_reg,
  input  wire logic [11:0] index_base,
  output logic      [11:0] addr,
  output logic             indexed
);
  always_comb begin
    indexed = 1'b0;
    if (access_sel) begin
      addr = {bank_select_reg, file_addr};
    end else if (ext_set_en && file_addr <= cis_pkg::LIT_OFS_MAX) begin
      addr    = index_base + {4'h0, file_addr};
      indexed = 1'b1;
    end else begin
      // access bank: low half in bank 0, high half in the sfr bank
      addr = file_addr[7] ? {4'hf, file_addr} : {4'h0, file_addr};
    end
  end
endmodule : cis_addr_gen

// File: rtl/cis_exec.sv
// executor for a subset of instructions of an 8-bit core
// Operation
// - an access operand of 0 picks the access bank, 1 picks the bank given by the bank select register.
// - with access 0 and the extended set on, a file operand up to 0x5f uses indexed literal offset mode.
// - branch on overflow (1110 0100 n) branches only when the overflow flag is 1.
// - branch on zero (1110 0000 n) branches only when the zero flag is 1; branches touch no flags.
// - a taken branch loads the counter with branch address plus 2 plus twice the signed offset.
// - a branch takes one cycle untaken and two taken, the second a no-operation flush.
// - the call first pushes call address plus 4 onto the return stack top.
// - with shadow operand 1 the call copies working, status and bank select to shadows, else no change.
// - the call loads its 20-bit literal into counter bits 20 to 1.
// - the call spans two words: 1110 110s with literal 7:0, then 1111 with literal 19:8.
// - the call takes two cycles, the second a no-operation.
// - clear file (0110 101a f) writes zero to the register and sets the zero flag in one cycle.
// - watchdog clear (0x0004) resets the watchdog counter in one cycle.
// - watchdog clear also zeroes the postscaler and sets timeout and power-down flags to 1.
`timescale 1ns/10ps
module cis_exec (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic [15:0]        instr_word,
  input  wire logic [15:0]        instr_next,
  input  wire logic               ext_set_en,
  input  wire logic [11:0]        index_base,
  input  wire logic [7:0]         working_in,
  input  wire logic [7:0]         dmem_rdata,
  input  wire logic               wdt_tick,
  output cis_pkg::cis_dmem_t      dmem_req,
  output logic      [20:0]        pc,
  output logic      [20:0]        stack_top,
  output logic                    stack_push,
  output logic      [7:0]         status,
  output logic      [3:0]         bank_select_reg,
  output cis_pkg::cis_shadow_t    shadow,
  output logic      [7:0]         watchdog_counter,
  output logic      [3:0]         wdt_postscaler,
  output logic                    timeout_flag,
  output logic                    powerdown_flag,
  output logic                    flush
);
  cis_pkg::cis_state_t  state, next_state;
  logic [20:0]          next_pc, next_stack_top;
  logic                 next_stack_push;
  logic [7:0]           next_status;
  cis_pkg::cis_shadow_t next_shadow;
  logic [7:0]           next_watchdog_counter;
  logic [3:0]           next_wdt_postscaler;
  logic                 next_timeout_flag, next_powerdown_flag;
  logic [11:0]          faddr;
  logic                 findexed;
  logic                 bit_toggle_op, clear_file_op, branch_on_ovf_op, branch_on_zero_op;
  logic                 call_op, watchdog_clear_op, taken;

  function automatic logic [20:0] branch_target(input logic [20:0] base, input logic [7:0] ofs);
    branch_target = base + cis_pkg::PC_STEP + {{12{ofs[7]}}, ofs, 1'b0};
  endfunction : branch_target

  cis_addr_gen u_addr (
    .file_addr      (instr_word[7:0]),
    .access_sel     (instr_word[8]),
    .ext_set_en     (ext_set_en),
    .bank_select_reg(bank_select_reg),
    .index_base     (index_base),
    .addr           (faddr),
    .indexed        (findexed)
  );

  always_comb begin
    bit_toggle_op     = instr_word[15:12] == cis_pkg::OP_TOGGLE_PFX;
    clear_file_op     = instr_word[15:9] == cis_pkg::OP_CLEAR_PFX;
    branch_on_ovf_op  = instr_word[15:8] == cis_pkg::OP_BR_OVF;
    branch_on_zero_op = instr_word[15:8] == cis_pkg::OP_BR_ZERO;
    call_op           = instr_word[15:9] == cis_pkg::OP_CALL_PFX
                        && instr_next[15:12] == cis_pkg::OP_CALL2_PFX;
    watchdog_clear_op = instr_word == cis_pkg::OP_WDT_CLR;
    taken             = (branch_on_ovf_op && status[cis_pkg::ST_OV])
                        || (branch_on_zero_op && status[cis_pkg::ST_Z]);
  end

  always_comb begin
    next_state            = cis_pkg::CIS_EXEC;
    next_pc               = pc + cis_pkg::PC_STEP;
    next_stack_top        = stack_top;
    next_stack_push       = 1'b0;
    next_status           = status;
    next_shadow           = shadow;
    next_watchdog_counter = watchdog_counter + {7'h00, wdt_tick};
    // postscaler counts counter wraps; no timeout is modelled here
    next_wdt_postscaler   = wdt_postscaler + {3'h0, wdt_tick && (&watchdog_counter)};
    next_timeout_flag     = timeout_flag;
    next_powerdown_flag   = powerdown_flag;
    dmem_req              = '0;
    dmem_req.addr         = faddr;
    dmem_req.indexed      = findexed;
    case (state)
      cis_pkg::CIS_FLUSH: begin
        // second cycle of a taken branch or call does nothing
        next_pc = pc;
      end
      default: begin
        if (bit_toggle_op) begin
          dmem_req.rd    = 1'b1;
          dmem_req.wr    = 1'b1;
          dmem_req.wdata = dmem_rdata ^ (8'h01 << instr_word[11:9]);
        end else if (clear_file_op) begin
          dmem_req.wr               = 1'b1;
          dmem_req.wdata            = cis_pkg::BYTE_RESET;
          next_status[cis_pkg::ST_Z] = 1'b1;
        end else if (taken) begin
          next_pc    = branch_target(pc, instr_word[7:0]);
          next_state = cis_pkg::CIS_FLUSH;
        end else if (call_op) begin
          next_stack_top  = pc + cis_pkg::PC_RET_OFS;
          next_stack_push = 1'b1;
          if (instr_word[8]) begin
            next_shadow = '{working: working_in, status: status, bank: bank_select_reg};
          end
          next_pc    = {instr_next[11:0], instr_word[7:0], 1'b0};
          next_state = cis_pkg::CIS_FLUSH;
        end else if (watchdog_clear_op) begin
          next_watchdog_counter = cis_pkg::WDT_RESET;
          next_wdt_postscaler   = cis_pkg::POST_RESET;
          next_timeout_flag     = 1'b1;
          next_powerdown_flag   = 1'b1;
        end
      end
    endcase
  end

  assign flush = state == cis_pkg::CIS_FLUSH;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state            <= cis_pkg::CIS_EXEC;
      pc               <= cis_pkg::PC_RESET;
      stack_top        <= cis_pkg::PC_RESET;
      stack_push       <= 1'b0;
      status           <= cis_pkg::BYTE_RESET;
      bank_select_reg  <= cis_pkg::BANK_RESET;
      shadow           <= '0;
      watchdog_counter <= cis_pkg::WDT_RESET;
      wdt_postscaler   <= cis_pkg::POST_RESET;
      timeout_flag     <= 1'b1;
      powerdown_flag   <= 1'b1;
    end else begin
      state            <= next_state;
      pc               <= next_pc;
      stack_top        <= next_stack_top;
      stack_push       <= next_stack_push;
      status           <= next_status;
      bank_select_reg  <= bank_select_reg;
      shadow           <= next_shadow;
      watchdog_counter <= next_watchdog_counter;
      wdt_postscaler   <= next_wdt_postscaler;
      timeout_flag     <= next_timeout_flag;
      powerdown_flag   <= next_powerdown_flag;
    end
  end

  property p_ovf_fallthru;
    @(posedge clk) disable iff (sys_rst)
    (!flush && branch_on_ovf_op && !status[cis_pkg::ST_OV]) |=> (pc == $past(pc) + 21'h2) && !flush;
  endproperty
  a_ovf_fallthru: assert property (p_ovf_fallthru) else $error("untaken overflow branch did not fall through");

  property p_zero_target;
    @(posedge clk) disable iff (sys_rst)
    (!flush && branch_on_zero_op && status[cis_pkg::ST_Z])
      |=> pc == $past(pc) + 21'h2 + {{12{$past(instr_word[7])}}, $past(instr_word[7:0]), 1'b0};
  endproperty
  a_zero_target: assert property (p_zero_target) else $error("zero branch target wrong");

  property p_branch_flags;
    @(posedge clk) disable iff (sys_rst)
    (!flush && (branch_on_zero_op || branch_on_ovf_op)) |=> $stable(status);
  endproperty
  a_branch_flags: assert property (p_branch_flags) else $error("branch altered status");

  property p_taken_two;
    @(posedge clk) disable iff (sys_rst)
    (!flush && taken) |=> flush ##1 (!flush && pc == $past(pc));
  endproperty
  a_taken_two: assert property (p_taken_two) else $error("taken branch not two cycles");

  property p_call_push;
    @(posedge clk) disable iff (sys_rst)
    (!flush && call_op && !taken) |=> stack_push && stack_top == $past(pc) + 21'h4 && flush;
  endproperty
  a_call_push: assert property (p_call_push) else $error("call push wrong");

  property p_call_noshadow;
    @(posedge clk) disable iff (sys_rst)
    (!flush && call_op && !instr_word[8]) |=> $stable(shadow);
  endproperty
  a_call_noshadow: assert property (p_call_noshadow) else $error("shadow changed with s=0");

  property p_call_target;
    @(posedge clk) disable iff (sys_rst)
    (!flush && call_op) |=> pc[20:1] == {$past(instr_next[11:0]), $past(instr_word[7:0])};
  endproperty
  a_call_target: assert property (p_call_target) else $error("call target wrong");

  property p_clear_file;
    @(posedge clk) disable iff (sys_rst)
    (!flush && clear_file_op) |-> dmem_req.wr && dmem_req.wdata == 8'h00 ##1 status[cis_pkg::ST_Z];
  endproperty
  a_clear_file: assert property (p_clear_file) else $error("clear file failed");

  // exactly the selected bit flips, and no flag moves
  property p_toggle_one_bit;
    @(posedge clk) disable iff (sys_rst)
    (!flush && bit_toggle_op) |-> dmem_req.rd && dmem_req.wr && $countones(dmem_req.wdata ^ dmem_rdata) == 1
      && dmem_req.wdata[instr_word[11:9]] != dmem_rdata[instr_word[11:9]] ##1 $stable(status);
  endproperty
  a_toggle_one_bit: assert property (p_toggle_one_bit) else $error("bit toggle wrong");

  property p_indexed_addr;
    @(posedge clk) disable iff (sys_rst)
    (!flush && (clear_file_op || bit_toggle_op) && !instr_word[8] && ext_set_en
      && instr_word[7:0] <= cis_pkg::LIT_OFS_MAX)
      |-> dmem_req.indexed && dmem_req.addr == index_base + {4'h0, instr_word[7:0]};
  endproperty
  a_indexed_addr: assert property (p_indexed_addr) else $error("indexed literal offset address wrong");

  property p_wdt_clr;
    @(posedge clk) disable iff (sys_rst)
    (!flush && watchdog_clear_op) |=> watchdog_counter == 8'h00 && wdt_postscaler == 4'h0
      && timeout_flag && powerdown_flag;
  endproperty
  a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog clear failed");
endmodule : cis_exec

// File: testbench/cis_mem_model.sv
// data memory model facing the executor
`timescale 1ns/10ps
module cis_mem_model (
  input  wire logic               clk,
  input  wire cis_pkg::cis_dmem_t dmem_req,
  output logic      [7:0]         dmem_rdata
);
  logic [7:0] mem [0:4095];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0] ^ 8'h5a;
    end
  end
  // unread cycles toggle, so stale data never looks valid
  always_comb begin
    dmem_rdata = dmem_req.rd ? mem[dmem_req.addr] : {4{clk, ~clk}};
  end
  always @(posedge clk) begin
    if (dmem_req.wr) begin
      mem[dmem_req.addr] <= dmem_req.wdata;
    end
  end
endmodule : cis_mem_model

// File: testbench/cis_exec_bench.sv
// self-checking bench for the instruction subset executor
`timescale 1ns/10ps
module cis_exec_bench;
  typedef struct {logic [15:0] instr; logic ext; logic [21:0] exp;} cis_row_t;
  logic                 clk = 1'b0;
  logic                 sys_rst = 1'b1;
  logic [15:0]          instr_word = 16'h0000;
  logic [15:0]          instr_next = 16'h0000;
  logic                 ext_set_en = 1'b0;
  logic [11:0]          index_base = 12'h300;
  logic [7:0]           working_in = 8'ha5;
  logic                 wdt_tick = 1'b0;
  logic [7:0]           dmem_rdata, status, watchdog_counter;
  cis_pkg::cis_dmem_t   dmem_req;
  cis_pkg::cis_shadow_t shadow;
  logic [20:0]          pc, stack_top, p;
  logic [3:0]           bank_select_reg, wdt_postscaler;
  logic                 stack_push, timeout_flag, powerdown_flag, flush;
  int                   n_mismatch = 0;
  int                   comparisons = 0;
  // expected {wr, indexed, addr, wdata}
  cis_row_t rows [9] = '{
    '{16'h6b90, 1'b0, {2'b10, 12'h090, 8'h00}},
    '{16'h6a20, 1'b0, {2'b10, 12'h020, 8'h00}},
    '{16'h6a90, 1'b0, {2'b10, 12'hf90, 8'h00}},
    '{16'h6b33, 1'b0, {2'b10, 12'h033, 8'h00}},
    '{16'h6a5f, 1'b1, {2'b11, 12'h35f, 8'h00}},
    '{16'h6a60, 1'b1, {2'b10, 12'h060, 8'h00}},
    '{16'h6b20, 1'b1, {2'b10, 12'h020, 8'h00}},
    '{16'h7610, 1'b0, {2'b10, 12'h010, 8'h42}},
    '{16'h7e11, 1'b0, {2'b10, 12'h011, 8'hcb}}};

  always #50 clk = ~clk;

  cis_exec i_dut (
    .clk(clk), .sys_rst(sys_rst), .instr_word(instr_word), .instr_next(instr_next),
    .ext_set_en(ext_set_en), .index_base(index_base), .working_in(working_in),
    .dmem_rdata(dmem_rdata), .wdt_tick(wdt_tick), .dmem_req(dmem_req), .pc(pc),
    .stack_top(stack_top), .stack_push(stack_push), .status(status),
    .bank_select_reg(bank_select_reg), .shadow(shadow), .watchdog_counter(watchdog_counter),
    .wdt_postscaler(wdt_postscaler), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .flush(flush));

  cis_mem_model i_mem (.clk(clk), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // inputs always move 10 ns after the rising edge
  task automatic tick;
    @(posedge clk);
    #10;
  endtask : tick

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #100000;
    n_mismatch++;
    give_verdict;
  end

  initial begin
    repeat (4) tick;
    sys_rst = 1'b0;
    chk({pc, status, timeout_flag, powerdown_flag}, {21'h0, 8'h00, 2'b11});
    foreach (rows[i]) begin
      p = pc;
      {instr_word, ext_set_en} = {rows[i].instr, rows[i].ext};
      #1 chk({dmem_req.wr, dmem_req.indexed, dmem_req.addr, dmem_req.wdata}, rows[i].exp);
      tick;
      chk({pc, status}, {p + cis_pkg::PC_STEP, 8'h04});
    end
    // overflow flag stays clear, so this branch must fall through
    p = pc;
    instr_word = 16'he405;
    tick;
    chk({pc, flush, status}, {p + cis_pkg::PC_STEP, 1'b0, 8'h04});
    p = pc;
    instr_word = 16'he07f;
    tick;
    chk({pc, flush, status}, {p + 21'h000100, 1'b1, 8'h04});
    instr_word = 16'h0000;
    tick;
    chk({pc, flush}, {p + 21'h000100, 1'b0});
    p = pc;
    instr_word = 16'he0fe;
    tick;
    chk({pc, flush}, {p - 21'h000002, 1'b1});
    instr_word = 16'h0000;
    tick;
    p = pc;
    {instr_word, instr_next, working_in} = {16'hed34, 16'hf123, 8'h3c};
    tick;
    chk({pc, stack_top, stack_push, flush}, {21'h024668, p + cis_pkg::PC_RET_OFS, 2'b11});
    chk(shadow, {8'h3c, 8'h04, 4'h0});
    {instr_word, instr_next} = {16'h0000, 16'h0000};
    tick;
    chk({pc, stack_push, flush}, {21'h024668, 2'b00});
    p = pc;
    {instr_word, instr_next, working_in} = {16'hec00, 16'hf000, 8'hc3};
    tick;
    chk({pc, stack_top, shadow}, {21'h0, p + cis_pkg::PC_RET_OFS, 8'h3c, 8'h04, 4'h0});
    instr_word = 16'h0000;
    tick;
    wdt_tick = 1'b1;
    repeat (3) tick;
    chk(watchdog_counter, 8'h03);
    // a full wrap bumps the postscaler, so the clear has something to undo
    repeat (256) tick;
    chk({watchdog_counter, wdt_postscaler}, {8'h03, 4'h1});
    {wdt_tick, instr_word} = {1'b0, cis_pkg::OP_WDT_CLR};
    tick;
    chk({watchdog_counter, wdt_postscaler, timeout_flag, powerdown_flag}, {12'h000, 2'b11});
    instr_word = 16'h0000;
    tick;
    // second reset in mid-run
    sys_rst = 1'b1;
    #1 chk({pc, stack_top}, 42'h0);
    chk({status, shadow}, 28'h0);
    tick;
    sys_rst = 1'b0;
    // zero flag was cleared by reset, so this branch must fall through
    instr_word = 16'he0fe;
    tick;
    chk({pc, flush}, {cis_pkg::PC_STEP, 1'b0});
    give_verdict;
  end
endmodule : cis_exec_bench
